// >>> rtl/sec_defs.svh
`ifndef SEC_DEFS_SVH
`define SEC_DEFS_SVH
// ------------------------------------------------
// Command decode constants
// ------------------------------------------------
`define SEC_TYPE_MEM   4'ha
`define SEC_TYPE_AUX   4'hb
`define SEC_SPC_IDP    2'h0
`define SEC_SPC_SEL    2'h1
`define SEC_WPR_TGT    7
`define SEC_WPR_LSB    1
`define SEC_WPR_MSB    3
// ------------------------------------------------
// Reset values of the stored settings
// ------------------------------------------------
`define SEC_WPR_RST    3'h0
`define SEC_SEL_RST    3'h0
// ------------------------------------------------
// Sizes and timing
// ------------------------------------------------
`define SEC_PAGE       64
`define SEC_ARRAY      16384
`define SEC_FIFO_DEPTH 8
`define SEC_T_WR_MS    5
`define SEC_CLK_KHZ    40000
`define SEC_T_WR_CYC   (`SEC_T_WR_MS * `SEC_CLK_KHZ)
`endif

// >>> rtl/sec_pkg.sv
`default_nettype none
package sec_pkg;
   // Serial protocol phase
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_DEV = 3'b001, ST_ADH = 3'b010,
      ST_ADL  = 3'b011, ST_WR  = 3'b100, ST_RD  = 3'b101
   } sec_st_t;
   // Self-timed write cycle phase
   typedef enum logic [1:0] {
      WC_IDLE = 2'b00, WC_COPY = 2'b01, WC_WAIT = 2'b10
   } sec_wc_t;
   // Target of a write sequence
   typedef enum logic [2:0] {
      K_ARR = 3'b000, K_WPR = 3'b001, K_IDP = 3'b010,
      K_SEL = 3'b011, K_NONE = 3'b100
   } sec_kind_t;
   // Protect register bits 3..1
   typedef struct packed {
      logic       en;
      logic [1:0] bp;
   } sec_wpr_t;
   // One buffered page byte
   typedef struct packed {
      logic [5:0] off;
      logic [7:0] dat;
   } sec_pw_t;
endpackage
`default_nettype wire

// >>> rtl/sec_eeprom.sv
`include "sec_defs.svh"
`default_nettype none

// ------------------------------------------------
// Page byte FIFO
// ------------------------------------------------
module sec_fifo #(
   parameter int W = 14,
   parameter int D = `SEC_FIFO_DEPTH
) (
   input  wire logic         mclk,
   input  wire logic         arst_n,
   input  wire logic         in_valid,
   output logic             in_ready,
   input  wire logic [W-1:0] in_data,
   output logic             out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]     out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] buf_r [D];
   logic [AW:0]  wp_r;
   logic [AW:0]  rp_r;

   // Full when pointers differ only in wrap bit
   assign in_ready  = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
   assign out_valid = wp_r != rp_r;
   assign out_data  = buf_r[rp_r[AW-1:0]];

   // Pointers
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         if (in_valid && in_ready) wp_r <= wp_r + 1'b1;
         if (out_valid && out_ready) rp_r <= rp_r + 1'b1;
      end
   end

   // Storage
   always_ff @(posedge mclk) begin
      if (in_valid && in_ready) buf_r[wp_r[AW-1:0]] <= in_data;
   end
endmodule // sec_fifo

// ------------------------------------------------
// Two-wire EEPROM command logic
// ------------------------------------------------
module sec_eeprom #(
   parameter int unsigned T_WR_CYC = `SEC_T_WR_CYC
) (
   input  wire logic mclk,
   input  wire logic arst_n,
   input  wire logic scl,
   input  wire logic sda_pin,
   output logic      sda_drv,
   output logic      sda_oe,
   output logic      wr_busy
);
   import sec_pkg::*;

   logic [1:0]      scl_s, sda_s;
   logic            scl_q, sda_q;
   logic            rise, fall, start, stop, busy, rx, ev8, ev9, ld_rd;
   sec_st_t         st_r, nst_r, nxt;
   sec_wc_t         wc_st_r;
   sec_kind_t       kind_r;
   sec_wpr_t        wpr_r, wnew_r;
   sec_pw_t         f_in, f_out;
   logic [3:0]      cnt_r;
   logic [7:0]      sh_r, ahi_r, rd_byte, row_r;
   logic [13:0]     addr_r;
   logic [6:0]      nb_r, ci_r;
   logic [2:0]      sel_r, snew_r;
   logic [63:0]     mask_r;
   logic [31:0]     wcnt_r;
   logic            aux_r, wtgt_r, mack_r, cid_r, sda_oe_r, busy_r;
   logic            ack, prot, wr_ok, f_ivld, f_irdy, f_ovld;
   logic [7:0]      mem  [`SEC_ARRAY];
   logic [7:0]      idp  [`SEC_PAGE];
   logic [7:0]      pbuf [`SEC_PAGE];

   // ------------------------------------------------
   // Pin synchronisers and bus events
   // ------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         scl_s <= 2'h3;
         sda_s <= 2'h3;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_s <= {scl_s[0], scl};
         sda_s <= {sda_s[0], sda_pin};
         scl_q <= scl_s[1];
         sda_q <= sda_s[1];
      end
   end

   // Edges, start and stop; bus is deaf while programming
   assign busy  = wc_st_r != WC_IDLE;
   assign rise  = scl_s[1] & ~scl_q;
   assign fall  = ~scl_s[1] & scl_q;
   assign start = !busy && scl_s[1] && scl_q && sda_q && !sda_s[1];
   assign stop  = !busy && scl_s[1] && scl_q && !sda_q && sda_s[1];
   assign rx    = st_r != ST_IDLE && st_r != ST_RD;
   assign ev8   = !busy && !start && !stop && fall && cnt_r == 4'h8;
   assign ev9   = !busy && !start && !stop && fall && cnt_r == 4'h9;
   assign ld_rd = ev9 && ((rx && nst_r == ST_RD) || (st_r == ST_RD && mack_r));

   // ------------------------------------------------
   // Decode of the received byte
   // ------------------------------------------------
   // Protected when upper address quarter at or above limit
   assign prot = wpr_r.en && (addr_r[13:12] >= (2'h3 - wpr_r.bp));

   // Read source: id page, protect register or array
   always_comb begin
      if (aux_r) rd_byte = idp[addr_r[5:0]];
      else if (wtgt_r) rd_byte = {4'h0, wpr_r, 1'b0};
      else rd_byte = mem[addr_r];
   end

   // Data byte accept and page push
   always_comb begin
      f_ivld = ev8 && st_r == ST_WR && ((kind_r == K_ARR && !prot) || kind_r == K_IDP);
      unique case (kind_r)
         K_ARR:   wr_ok = !prot && f_irdy;
         K_IDP:   wr_ok = f_irdy;
         K_WPR:   wr_ok = 1'b1;
         K_SEL:   wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   // Acknowledge decision and following phase
   always_comb begin
      unique case (st_r)
         ST_DEV: begin
            ack = (sh_r[7:4] == `SEC_TYPE_MEM || sh_r[7:4] == `SEC_TYPE_AUX)
                  && sh_r[3:1] == sel_r;
            nxt = sh_r[0] ? ST_RD : ST_ADH;
         end
         ST_ADH: begin
            ack = 1'b1;
            nxt = ST_ADL;
         end
         ST_ADL: begin
            ack = 1'b1;
            nxt = ST_WR;
         end
         ST_WR: begin
            ack = wr_ok;
            nxt = ST_WR;
         end
         default: begin
            ack = 1'b0;
            nxt = ST_IDLE;
         end
      endcase
   end

   // ------------------------------------------------
   // Serial protocol state machine
   // ------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_r     <= ST_IDLE;
         nst_r    <= ST_IDLE;
         cnt_r    <= 4'h0;
         sh_r     <= 8'h00;
         sda_oe_r <= 1'b0;
         mack_r   <= 1'b0;
      end else if (busy) begin
         st_r     <= ST_IDLE;
         sda_oe_r <= 1'b0;
      end else if (start) begin
         st_r     <= ST_DEV;
         cnt_r    <= 4'h0;
         sda_oe_r <= 1'b0;
      end else if (stop) begin
         st_r     <= ST_IDLE;
         sda_oe_r <= 1'b0;
      end else if (st_r == ST_RD) begin
         if (rise && cnt_r == 4'h8) begin
            mack_r <= ~sda_s[1];
            cnt_r  <= 4'h9;
         end else if (rise) begin
            cnt_r <= cnt_r + 4'h1;
         end else if (ld_rd) begin
            sda_oe_r <= ~rd_byte[7];
            sh_r     <= {rd_byte[6:0], 1'b0};
            cnt_r    <= 4'h0;
         end else if (ev9) begin
            st_r <= ST_IDLE;
         end else if (fall && cnt_r == 4'h8) begin
            sda_oe_r <= 1'b0;
         end else if (fall) begin
            sda_oe_r <= ~sh_r[7];
            sh_r     <= {sh_r[6:0], 1'b0};
         end
      end else if (rx) begin
         if (rise && cnt_r != 4'h8) begin
            sh_r  <= {sh_r[6:0], sda_s[1]};
            cnt_r <= cnt_r + 4'h1;
         end else if (rise) begin
            cnt_r <= 4'h9;
         end else if (ev8) begin
            sda_oe_r <= ack;
            nst_r    <= ack ? nxt : ST_IDLE;
         end else if (ld_rd) begin
            st_r     <= ST_RD;
            cnt_r    <= 4'h0;
            sda_oe_r <= ~rd_byte[7];
            sh_r     <= {rd_byte[6:0], 1'b0};
         end else if (ev9) begin
            st_r     <= nst_r;
            cnt_r    <= 4'h0;
            sda_oe_r <= 1'b0;
         end
      end
   end

   // ------------------------------------------------
   // Command capture and address counter
   // ------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         addr_r <= 14'h0000;
         ahi_r  <= 8'h00;
         aux_r  <= 1'b0;
         wtgt_r <= 1'b0;
         kind_r <= K_NONE;
         nb_r   <= 7'h00;
         wnew_r <= `SEC_WPR_RST;
         snew_r <= `SEC_SEL_RST;
      end else if (ld_rd) begin
         if (aux_r) addr_r[5:0] <= addr_r[5:0] + 6'h01;
         else if (!wtgt_r) addr_r <= addr_r + 14'h0001;
      end else if (ev8 && ack) begin
         unique case (st_r)
            ST_DEV: begin
               aux_r <= sh_r[4];
               nb_r  <= 7'h00;
            end
            ST_ADH: ahi_r <= sh_r;
            ST_ADL: begin
               addr_r <= {ahi_r[5:0], sh_r};
               wtgt_r <= !aux_r && ahi_r[`SEC_WPR_TGT];
               if (!aux_r) kind_r <= ahi_r[`SEC_WPR_TGT] ? K_WPR : K_ARR;
               else if (ahi_r[2:1] == `SEC_SPC_IDP) kind_r <= K_IDP;
               else if (ahi_r[2:1] == `SEC_SPC_SEL) kind_r <= K_SEL;
               else kind_r <= K_NONE;
            end
            ST_WR: begin
               if (nb_r != 7'h7f) nb_r <= nb_r + 7'h01;
               if (kind_r == K_ARR || kind_r == K_IDP)
                  addr_r[5:0] <= addr_r[5:0] + 6'h01;
               if (kind_r == K_WPR && nb_r == 7'h00)
                  wnew_r <= sh_r[`SEC_WPR_MSB:`SEC_WPR_LSB];
               if (kind_r == K_SEL && nb_r == 7'h00) snew_r <= sh_r[2:0];
            end
            default: nb_r <= nb_r;
         endcase
      end
   end

   // ------------------------------------------------
   // Page buffer and self-timed write cycle
   // ------------------------------------------------
   assign f_in = '{off: addr_r[5:0], dat: sh_r};

   sec_fifo #(.W(14), .D(`SEC_FIFO_DEPTH)) u_fifo (
      .mclk      (mclk),
      .arst_n    (arst_n),
      .in_valid  (f_ivld),
      .in_ready  (f_irdy),
      .in_data   (f_in),
      .out_valid (f_ovld),
      .out_ready (!busy),
      .out_data  (f_out)
   );

   // Page staging bytes
   always_ff @(posedge mclk) begin
      if (f_ovld && !busy) pbuf[f_out.off] <= f_out.dat;
   end

   // Commit staged bytes into the array or id page
   always_ff @(posedge mclk) begin
      if (wc_st_r == WC_COPY && mask_r[ci_r[5:0]]) begin
         if (cid_r) idp[ci_r[5:0]] <= pbuf[ci_r[5:0]];
         else mem[{row_r, ci_r[5:0]}] <= pbuf[ci_r[5:0]];
      end
   end

   // Write cycle sequencer and stored settings
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wc_st_r <= WC_IDLE;
         mask_r  <= 64'h0;
         ci_r    <= 7'h00;
         wcnt_r  <= 32'h0;
         row_r   <= 8'h00;
         cid_r   <= 1'b0;
         wpr_r   <= `SEC_WPR_RST;
         sel_r   <= `SEC_SEL_RST;
      end else begin
         unique case (wc_st_r)
            WC_IDLE: begin
               if (f_ovld) mask_r[f_out.off] <= 1'b1;
               if (start) mask_r <= 64'h0;
               if (stop && st_r == ST_WR && nb_r != 7'h00) begin
                  wcnt_r <= 32'h0;
                  ci_r   <= 7'h00;
                  row_r  <= addr_r[13:6];
                  cid_r  <= kind_r == K_IDP;
                  if ((kind_r == K_ARR || kind_r == K_IDP) && mask_r != 64'h0)
                     wc_st_r <= WC_COPY;
                  if (kind_r == K_WPR && nb_r == 7'h01) begin
                     wpr_r   <= wnew_r;
                     wc_st_r <= WC_WAIT;
                  end
                  if (kind_r == K_SEL && nb_r == 7'h01) begin
                     sel_r   <= snew_r;
                     wc_st_r <= WC_WAIT;
                  end
               end
            end
            WC_COPY: begin
               ci_r <= ci_r + 7'h01;
               if (ci_r == 7'h3f) begin
                  mask_r  <= 64'h0;
                  wc_st_r <= WC_WAIT;
               end
            end
            WC_WAIT: begin
               wcnt_r <= wcnt_r + 32'h1;
               if (wcnt_r >= 32'(T_WR_CYC - 1)) wc_st_r <= WC_IDLE;
            end
            default: wc_st_r <= WC_IDLE;
         endcase
      end
   end

   // ------------------------------------------------
   // Registered outputs
   // ------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sda_drv <= 1'b0;
         busy_r  <= 1'b0;
      end else begin
         sda_drv <= 1'b0; // Open drain: only ever pulls low
         busy_r  <= busy;
      end
   end
   assign sda_oe  = sda_oe_r;
   assign wr_busy = busy_r;

   // ------------------------------------------------
   // Assertions
   // ------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   a_data_ack: assert property (
      (st_r == ST_WR && ev8 && kind_r == K_ARR && !prot && f_irdy) |=> sda_oe_r)
      else $error("data byte not acknowledged");
   a_page_row: assert property (
      (st_r == ST_WR && ev8 && ack) |=> addr_r[13:6] == $past(addr_r[13:6]))
      else $error("page row changed during page write");
   a_page_wrap: assert property (
      (st_r == ST_WR && ev8 && ack && kind_r == K_ARR && addr_r[5:0] == 6'h3f)
      |=> addr_r[5:0] == 6'h00)
      else $error("in-page address did not wrap");
   a_busy_quiet: assert property (
      busy |=> !sda_oe_r)
      else $error("line driven during write cycle");
   a_prot_nack: assert property (
      (st_r == ST_WR && ev8 && kind_r == K_ARR && prot) |=> !sda_oe_r ##1 !sda_oe_r)
      else $error("protected byte acknowledged");
   a_wpr_keep: assert property (
      (stop && st_r == ST_WR && kind_r == K_WPR && nb_r != 7'h01)
      |=> $stable(wpr_r) [*3])
      else $error("protect register changed by multi-byte write");
   // Bit 7 reads zero, so the first bit pulls the line low
   a_wpr_read: assert property (
      (ld_rd && !aux_r && wtgt_r)
      |=> sda_oe_r && sh_r[7:5] == 3'h0 && sh_r[4:2] == wpr_r && sh_r[1:0] == 2'h0)
      else $error("protect register read format wrong");
   a_rd_inc: assert property (
      (ld_rd && !aux_r && !wtgt_r) |=> addr_r == $past(addr_r) + 14'h0001)
      else $error("address counter not incremented after read byte");
   a_sel_nack: assert property (
      (st_r == ST_DEV && ev8 && sh_r[3:1] != sel_r) |=> !sda_oe_r)
      else $error("mismatched select acknowledged");
   a_start_abort: assert property (
      (start && !busy) |=> st_r == ST_DEV && mask_r == 64'h0)
      else $error("start did not cancel pending write");

   c_page_commit: cover property (wc_st_r == WC_IDLE ##1 wc_st_r == WC_COPY);
   c_seq_read: cover property (st_r == ST_RD && ld_rd);
   c_poll_nack: cover property (busy && scl_s[1] && !scl_q);
   c_wpr_write: cover property (wc_st_r == WC_IDLE && stop && kind_r == K_WPR);
endmodule // sec_eeprom
`default_nettype wire

// >>> verification/sec_host_model.sv
`default_nettype none

// ------------------------------------------------
// Two-wire bus controller model
// ------------------------------------------------
module sec_host_model (
   input  wire logic mclk,
   input  wire logic sda,
   output var logic  scl,
   output var logic  sda_low
);
   timeunit 1ns;
   timeprecision 100ps;
   // Bus idles with clock high and data released
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // Wait whole system clocks, then step just past the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // One bit slot of 8 mclk; sample just before the fall
   task automatic bit_io(input logic b, output logic r);
      sda_low = ~b;
      cyc(2);
      scl = 1'b1;
      cyc(4);
      r = sda;
      scl = 1'b0;
      cyc(2);
   endtask

   // Start, also usable as a repeated start
   task automatic start();
      sda_low = 1'b0;
      cyc(2);
      scl = 1'b1;
      cyc(4);
      sda_low = 1'b1;
      cyc(4);
      scl = 1'b0;
      cyc(2);
   endtask

   // Stop, clock left high afterwards
   task automatic stop();
      sda_low = 1'b1;
      cyc(2);
      scl = 1'b1;
      cyc(4);
      sda_low = 1'b0;
      cyc(4);
   endtask

   // Byte out, most significant bit first
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask

   // Byte in; no acknowledge ends the read
   task automatic rd_byte(output logic [7:0] d, input logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, d[i]);
      bit_io(~ack, r);
   endtask
endmodule // sec_host_model

`default_nettype wire

// >>> verification/tb.sv
`default_nettype none

// ------------------------------------------------
// Command logic bench
// ------------------------------------------------
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] MEM = 8'ha0;
   localparam logic [7:0] AUX = 8'hb0;
   logic       mclk;
   logic       arst_n;
   wire logic  scl;
   wire logic  sda_low;
   wire logic  sda_pin;
   wire logic  sda_drv;
   wire logic  sda_oe;
   wire logic  wr_busy;
   logic       ak;
   logic [7:0] rb [0:1];
   int         failures = 0;
   int         compares = 0;
   int         cycles = 0;

   // Open-drain wire with pull-up
   assign sda_pin = ~((sda_oe & ~sda_drv) | sda_low);

   sec_eeprom #(.T_WR_CYC(200)) dut (
      .mclk    (mclk),
      .arst_n  (arst_n),
      .scl     (scl),
      .sda_pin (sda_pin),
      .sda_drv (sda_drv),
      .sda_oe  (sda_oe),
      .wr_busy (wr_busy)
   );

   sec_host_model m (
      .mclk    (mclk),
      .sda     (sda_pin),
      .scl     (scl),
      .sda_low (sda_low)
   );

   // Clock
   initial mclk = 1'b0;
   always #12.5 mclk = ~mclk;

   // Hang guard
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 60000) begin
         failures++;
         test_done();
      end
   end

   // ------------------------------------------------
   // Helpers
   // ------------------------------------------------
   task automatic test_done();
      if (failures == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask

   task automatic chkb(input string n, input logic e, input logic g);
      chk(n, {7'h0, e}, {7'h0, g});
   endtask

   // Poll while busy, then wait out the write cycle
   task automatic idle();
      if (wr_busy === 1'b1) begin
         m.start();
         m.wr_byte(MEM, ak);
         chkb("poll ack", 1'b0, ak);
         m.stop();
      end
      for (int i = 0; i < 2000 && wr_busy !== 1'b0; i++)
         m.cyc(1);
      chkb("busy end", 1'b0, wr_busy);
   endtask

   // Start, device byte, two address bytes
   task automatic addr(input logic [7:0] dv, input logic [15:0] a);
      m.start();
      m.wr_byte(dv, ak);
      chkb("dev ack", 1'b1, ak);
      m.wr_byte(a[15:8], ak);
      chkb("hi ack", 1'b1, ak);
      m.wr_byte(a[7:0], ak);
      chkb("lo ack", 1'b1, ak);
   endtask

   // Write n bytes v, v+1, ... expecting ack level ea
   task automatic pw(input logic [7:0] dv, input logic [15:0] a, input int n,
                     input logic [7:0] v, input logic ea);
      addr(dv, a);
      for (int k = 0; k < n; k++) begin
         m.wr_byte(v + 8'(k), ak);
         chkb("data ack", ea, ak);
      end
      m.stop();
      idle();
   endtask

   // Current read of n bytes, last one not acknowledged
   task automatic cur(input logic [7:0] dv, input int n);
      m.start();
      m.wr_byte(dv | 8'h01, ak);
      chkb("rd ack", 1'b1, ak);
      for (int k = 0; k < n; k++)
         m.rd_byte(rb[k], k < n - 1);
      m.stop();
   endtask

   task automatic rd(input logic [7:0] dv, input logic [15:0] a, input int n);
      addr(dv, a);
      cur(dv, n);
   endtask

   // ------------------------------------------------
   // Scenarios
   // ------------------------------------------------
   task automatic t_reset();
      pw(MEM, 16'h0000, 1, 8'h3c, 1'b1);
      arst_n = 1'b0;
      m.cyc(5);
      chkb("oe in reset", 1'b0, sda_oe);
      chkb("busy in reset", 1'b0, wr_busy);
      chkb("drive level", 1'b0, sda_drv);
      arst_n = 1'b1;
      m.cyc(4);
      cur(MEM, 1);
      chk("rd at zero", 8'h3c, rb[0]);
      rd(MEM, 16'h8000, 1);
      chk("wpr reset", 8'h00, rb[0]);
   endtask

   task automatic t_page();
      addr(MEM, 16'h017e);
      for (int k = 0; k < 65; k++) begin
         m.wr_byte(8'h10 + 8'(k), ak);
         chkb("page ack", 1'b1, ak);
      end
      m.stop();
      chkb("busy", 1'b1, wr_busy);
      idle();
      cur(MEM, 1);
      chk("after write", 8'h11, rb[0]);
      rd(MEM, 16'h017e, 2);
      chk("overwritten", 8'h50, rb[0]);
      chk("page end", 8'h11, rb[1]);
      rd(MEM, 16'h0140, 1);
      chk("row start", 8'h12, rb[0]);
   endtask

   task automatic t_seq();
      pw(MEM, 16'h3fff, 1, 8'hc3, 1'b1);
      rd(MEM, 16'h3fff, 2);
      chk("top", 8'hc3, rb[0]);
      chk("rolled", 8'h3c, rb[1]);
   endtask

   // Pending byte at 0x10 must be dropped by the new start
   task automatic t_cancel();
      pw(MEM, 16'h0010, 1, 8'h11, 1'b1);
      addr(MEM, 16'h0010);
      m.wr_byte(8'h22, ak);
      chkb("pending ack", 1'b1, ak);
      pw(MEM, 16'h0011, 1, 8'h33, 1'b1);
      rd(MEM, 16'h0010, 2);
      chk("cancelled", 8'h11, rb[0]);
      chk("new write", 8'h33, rb[1]);
      chkb("no cycle", 1'b0, wr_busy);
   endtask

   task automatic t_prot();
      logic [15:0] lo;
      for (int b = 0; b < 4; b++) begin
         lo = 16'h3000 - 16'(b) * 16'h1000;
         pw(MEM, 16'h8000, 1, {4'hf, 1'b1, 2'(b), 1'b1}, 1'b1);
         rd(MEM, 16'hffff, 2);
         chk("wpr", {4'h0, 1'b1, 2'(b), 1'b0}, rb[0]);
         chk("wpr again", {4'h0, 1'b1, 2'(b), 1'b0}, rb[1]);
         pw(MEM, lo, 1, 8'h5a, 1'b0);
         if (b < 3)
            pw(MEM, lo - 16'h1, 1, 8'h5a, 1'b1);
      end
      pw(MEM, 16'h8000, 1, 8'h06, 1'b1);
      pw(MEM, 16'h3fff, 1, 8'h77, 1'b1);
      pw(MEM, 16'h8000, 2, 8'h0e, 1'b1);
      rd(MEM, 16'h8000, 1);
      chk("wpr kept", 8'h06, rb[0]);
      pw(MEM, 16'h8000, 1, 8'h00, 1'b1);
   endtask

   task automatic t_sel();
      pw(AUX, 16'h0200, 1, 8'hfd, 1'b1);
      m.start();
      m.wr_byte(MEM, ak);
      chkb("old sel", 1'b0, ak);
      m.stop();
      m.start();
      m.wr_byte(8'h9a, ak);
      chkb("bad type", 1'b0, ak);
      m.stop();
      rd(8'haa, 16'h3fff, 1);
      chk("new sel", 8'h77, rb[0]);
      pw(8'hba, 16'h0200, 1, 8'hf8, 1'b1);
   endtask

   task automatic t_id();
      pw(AUX, 16'h39c5, 2, 8'h5a, 1'b1);
      rd(AUX, 16'hf005, 2);
      chk("id first", 8'h5a, rb[0]);
      chk("id second", 8'h5b, rb[1]);
      pw(AUX, 16'h0400, 1, 8'h99, 1'b0);
   endtask

   // Main sequence
   initial begin
      arst_n = 1'b0;
      repeat (5) @(posedge mclk);
      #1 arst_n = 1'b1;
      m.cyc(4);
      t_reset();
      t_page();
      t_seq();
      t_cancel();
      t_prot();
      t_sel();
      t_id();
      test_done();
   end
endmodule // tb

`default_nettype wire
